/* dofs_pkg.sv */
// package: constants, register map and carrier types of the output selector
// assumes one 25 MHz system clock shared by all users
package dofs_pkg;

  localparam int CLK_HZ = 25_000_000;
  localparam int MS_PER_S = 1000;
  localparam int Z_HOLD_S = 10;
  localparam int MS_TICK_CYCLES = CLK_HZ / MS_PER_S;
  localparam int Z_HOLD_CYCLES = Z_HOLD_S * CLK_HZ;

  localparam int CODE_W = 6;
  localparam int NCODE = 64;
  localparam int NTERM = 4;
  localparam int NCHAN = 3;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int MS_CNT_W = 15;
  localparam int Z_CNT_W = 28;
  localparam int TIME_W = 16;

  // terminal indices
  localparam int T_OC = 0;
  localparam int T_FAST = 1;
  localparam int T_RLY1 = 2;
  localparam int T_RLY2 = 3;

  // polarity bit of each terminal
  localparam int POL_BIT_OC = 0;
  localparam int POL_BIT_FAST = 3;
  localparam int POL_BIT_RLY1 = 4;
  localparam int POL_BIT_RLY2 = 5;

  // function codes
  localparam int CODE_NONE = 0;
  localparam int CODE_RUN = 1;
  localparam int CODE_RUN_FWD = 2;
  localparam int CODE_RUN_REV = 3;
  localparam int CODE_JOG = 4;
  localparam int CODE_FAULT = 5;
  localparam int CODE_ZERO_SPD = 9;
  localparam int CODE_UPPER = 10;
  localparam int CODE_LOWER = 11;
  localparam int CODE_READY = 12;
  localparam int CODE_PRE_EXC = 13;
  localparam int CODE_OVERLOAD = 14;
  localparam int CODE_UNDERLOAD = 15;
  localparam int CODE_SEQ_STAGE = 16;
  localparam int CODE_SEQ_CYCLE = 17;
  localparam int CODE_EXT_FAULT = 20;
  localparam int CODE_VIRT0 = 23;
  localparam int CODE_DC_BUS = 26;
  localparam int CODE_INDEX = 27;
  localparam int CODE_SUPERPOSE = 28;
  localparam int CODE_SAFE_OFF = 29;
  localparam int CODE_POS_DONE = 30;
  localparam int CODE_ZERO_DONE = 31;
  localparam int CODE_INDEX_DONE = 32;
  localparam int CODE_MODE_SW = 36;
  localparam int CODE_REACH = 37;
  localparam int CODE_CARD_OUT = 41;

  // register byte addresses
  localparam logic [7:0] A_FSEL0 = 8'h00;
  localparam logic [7:0] A_FSEL_STEP = 8'h04;
  localparam logic [7:0] A_POLARITY = 8'h10;
  localparam logic [7:0] A_FAST_MODE = 8'h14;
  localparam logic [7:0] A_CARD_EN = 8'h18;
  localparam logic [7:0] A_VIRT = 8'h1c;
  localparam logic [7:0] A_PREALARM = 8'h20;
  localparam logic [7:0] A_REACH = 8'h24;
  localparam logic [7:0] A_STATUS = 8'h28;

  // reset values
  localparam logic [5:0] RST_FSEL_OC = 6'h00;
  localparam logic [5:0] RST_FSEL_FAST = 6'h00;
  localparam logic [5:0] RST_FSEL_RLY1 = 6'h01;
  localparam logic [5:0] RST_FSEL_RLY2 = 6'h05;
  localparam logic [7:0] RST_POLARITY = 8'h00;
  localparam logic RST_FAST_MODE = 1'b0;
  localparam logic [7:0] CARD_EN_ON = 8'h01;

  // conditions delivered by the rest of the drive, same clock
  typedef struct packed {
    logic running;
    logic run_fwd;
    logic jogging;
    logic freq_out_nz;
    logic fault;
    logic out_freq_zero;
    logic ref_freq_zero;
    logic at_upper;
    logic at_lower;
    logic main_pwr_ok;
    logic ctrl_pwr_ok;
    logic protect_active;
    logic ready;
    logic pre_excite;
    logic overload_over;
    logic underload_over;
    logic seq_stage_done;
    logic seq_cycle_done;
    logic dc_bus_above_uv;
    logic pulse_superpose;
    logic safe_torque_off;
    logic pos_done;
    logic zero_done;
    logic index_done;
    logic mode_switch_done;
    logic card_first_out;
    logic [15:0] ramp_ref_freq;
  } dofs_drive_s;

endpackage

/* dofs_term_select.sv */
// one terminal's function selector: picks a condition by its code
// assumes the condition vector holds zero for unused codes
`timescale 1ns/1ps

module dofs_term_select (
  input wire logic [dofs_pkg::NCODE-1:0] cond_vec,
  input wire logic [dofs_pkg::CODE_W-1:0] code,
  output logic sel_out
);

  always_comb begin
    sel_out = 1'b0;
    if (code != 6'(dofs_pkg::CODE_NONE)) begin
      sel_out = cond_vec[code];
    end
  end

endmodule

/* dofs_output_select.sv */
// digital output function selector: four terminals, register port
// assumes drive conditions on clk_sys; pins fed through synchronisers
//
// The implementer's own choices: the register addresses and the plain strobed port.
`timescale 1ns/1ps

// What this block does
// - code zero leaves terminal inactive
// - codes 1-3: running, forward, reverse with frequency
// - code 5 follows drive fault
// - code 9: running with both frequencies zero
// - codes 10, 11: upper, lower limit reached
// - code 12: powers up, no protection, ready
// - code 13 follows pre-excitation
// - codes 14, 15 after pre-alarm time elapses
// - codes 16, 17 signal sequencer stage, cycle
// - code 20 follows external fault input
// - codes 23-25 follow written virtual bits
// - code 26 while bus above undervoltage
// - code 27 holds ten seconds after index
// - code 28 follows pulse superposition
// - code 29 follows safe torque off fault
// - codes 30-32 positioning, zeroing, indexing done
// - code 36 after control switchover completes
// - code 37 ramp reference above level
// - code 41 passes card output when enabled
// - one code may serve several terminals
// - fast terminal pulse or digital mode
// - polarity bit inverts, except the fast terminal in pulse mode; cleared at reset
// - codes span the full six-bit range
module dofs_output_select #(
  parameter int MS_TICK_CYCLES = dofs_pkg::MS_TICK_CYCLES,
  parameter int Z_HOLD_CYCLES = dofs_pkg::Z_HOLD_CYCLES
) (
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic [dofs_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [dofs_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [dofs_pkg::DATA_W-1:0] reg_rdata,
  input wire dofs_pkg::dofs_drive_s drive,
  input wire logic ext_fault_pin,
  input wire logic encoder_index_pin,
  input wire logic fast_pulse_src,
  output logic open_collector_out,
  output logic fast_pulse_out,
  output logic relay1_out,
  output logic relay2_out
);

  typedef struct packed {
    logic [dofs_pkg::NTERM-1:0][dofs_pkg::CODE_W-1:0] fsel;
    logic [7:0] polarity;
    logic fast_mode;
    logic [7:0] card_en;
    logic [dofs_pkg::NCHAN-1:0][dofs_pkg::NTERM-1:0] virt;
    logic [dofs_pkg::TIME_W-1:0] prealarm_ms;
    logic [dofs_pkg::TIME_W-1:0] reach_level;
    logic [dofs_pkg::DATA_W-1:0] rdata;
    logic ext_s1;
    logic ext_s2;
    logic z_s1;
    logic z_s2;
    logic z_s3;
    logic [dofs_pkg::MS_CNT_W-1:0] ms_cnt;
    logic ms_tick;
    logic [dofs_pkg::TIME_W-1:0] ol_cnt;
    logic [dofs_pkg::TIME_W-1:0] ul_cnt;
    logic ol_alarm;
    logic ul_alarm;
    logic [dofs_pkg::Z_CNT_W-1:0] z_cnt;
    logic z_hold;
    logic [dofs_pkg::NTERM-1:0] term;
  } dofs_state_s;

  localparam dofs_state_s STATE_RST = '{
    fsel: {dofs_pkg::RST_FSEL_RLY2, dofs_pkg::RST_FSEL_RLY1,
           dofs_pkg::RST_FSEL_FAST, dofs_pkg::RST_FSEL_OC},
    polarity: dofs_pkg::RST_POLARITY,
    fast_mode: dofs_pkg::RST_FAST_MODE,
    default: '0
  };

  localparam logic [dofs_pkg::MS_CNT_W-1:0] MS_LAST =
    dofs_pkg::MS_CNT_W'(MS_TICK_CYCLES - 1);
  localparam logic [dofs_pkg::Z_CNT_W-1:0] Z_LAST =
    dofs_pkg::Z_CNT_W'(Z_HOLD_CYCLES - 1);

  dofs_state_s state_reg;
  dofs_state_s state_next;
  logic [dofs_pkg::NCODE-1:0] cond_common;
  logic [dofs_pkg::NTERM-1:0][dofs_pkg::NCODE-1:0] cond_term;
  logic [dofs_pkg::NTERM-1:0] sel;
  logic [dofs_pkg::NTERM-1:0] pol_vec;
  logic z_edge;

  assign z_edge = state_reg.z_s2 & ~state_reg.z_s3;
  assign pol_vec = {state_reg.polarity[dofs_pkg::POL_BIT_RLY2],
                    state_reg.polarity[dofs_pkg::POL_BIT_RLY1],
                    state_reg.polarity[dofs_pkg::POL_BIT_FAST],
                    state_reg.polarity[dofs_pkg::POL_BIT_OC]};

  // conditions shared by every terminal
  always_comb begin
    cond_common = '0;
    cond_common[dofs_pkg::CODE_NONE] = 1'b0;
    cond_common[dofs_pkg::CODE_RUN] =
      drive.running & drive.freq_out_nz;
    cond_common[dofs_pkg::CODE_RUN_FWD] =
      drive.running & drive.run_fwd & drive.freq_out_nz;
    cond_common[dofs_pkg::CODE_RUN_REV] =
      drive.running & ~drive.run_fwd & drive.freq_out_nz;
    cond_common[dofs_pkg::CODE_JOG] = drive.jogging & drive.freq_out_nz;
    cond_common[dofs_pkg::CODE_FAULT] = drive.fault;
    cond_common[dofs_pkg::CODE_ZERO_SPD] = drive.running &
      drive.out_freq_zero & drive.ref_freq_zero;
    cond_common[dofs_pkg::CODE_UPPER] = drive.at_upper;
    cond_common[dofs_pkg::CODE_LOWER] = drive.at_lower;
    cond_common[dofs_pkg::CODE_READY] = drive.main_pwr_ok &
      drive.ctrl_pwr_ok & ~drive.protect_active & drive.ready;
    cond_common[dofs_pkg::CODE_PRE_EXC] = drive.pre_excite;
    cond_common[dofs_pkg::CODE_OVERLOAD] = state_reg.ol_alarm;
    cond_common[dofs_pkg::CODE_UNDERLOAD] = state_reg.ul_alarm;
    cond_common[dofs_pkg::CODE_SEQ_STAGE] = drive.seq_stage_done;
    cond_common[dofs_pkg::CODE_SEQ_CYCLE] = drive.seq_cycle_done;
    cond_common[dofs_pkg::CODE_EXT_FAULT] = state_reg.ext_s2;
    cond_common[dofs_pkg::CODE_DC_BUS] = drive.dc_bus_above_uv;
    cond_common[dofs_pkg::CODE_INDEX] = state_reg.z_hold;
    cond_common[dofs_pkg::CODE_SUPERPOSE] = drive.pulse_superpose;
    cond_common[dofs_pkg::CODE_SAFE_OFF] = drive.safe_torque_off;
    cond_common[dofs_pkg::CODE_POS_DONE] = drive.pos_done;
    cond_common[dofs_pkg::CODE_ZERO_DONE] = drive.zero_done;
    cond_common[dofs_pkg::CODE_INDEX_DONE] = drive.index_done;
    cond_common[dofs_pkg::CODE_MODE_SW] = drive.mode_switch_done;
    cond_common[dofs_pkg::CODE_REACH] =
      drive.ramp_ref_freq > state_reg.reach_level;
    cond_common[dofs_pkg::CODE_CARD_OUT] = drive.card_first_out &
      (state_reg.card_en == dofs_pkg::CARD_EN_ON);
  end

  // per terminal: shared conditions plus its own virtual bits
  always_comb begin
    for (int t = 0; t < dofs_pkg::NTERM; t++) begin
      cond_term[t] = cond_common;
      for (int c = 0; c < dofs_pkg::NCHAN; c++) begin
        cond_term[t][dofs_pkg::CODE_VIRT0 + c] = state_reg.virt[c][t];
      end
    end
  end

  // one selector per terminal, each with its own code
  for (genvar t = 0; t < dofs_pkg::NTERM; t++) begin : g_term
    dofs_term_select u_sel (
      .cond_vec(cond_term[t]),
      .code(state_reg.fsel[t]),
      .sel_out(sel[t])
    );
  end

  always_comb begin
    state_next = state_reg;

    // pin synchronisers and index edge history
    state_next.ext_s1 = ext_fault_pin;
    state_next.ext_s2 = state_reg.ext_s1;
    state_next.z_s1 = encoder_index_pin;
    state_next.z_s2 = state_reg.z_s1;
    state_next.z_s3 = state_reg.z_s2;

    // millisecond tick for the pre-alarm timers
    state_next.ms_tick = 1'b0;
    if (state_reg.ms_cnt == MS_LAST) begin
      state_next.ms_cnt = '0;
      state_next.ms_tick = 1'b1;
    end else begin
      state_next.ms_cnt = state_reg.ms_cnt + 1'b1;
    end

    // overload pre-alarm: condition must persist for the set time
    if (!drive.overload_over) begin
      state_next.ol_cnt = '0;
      state_next.ol_alarm = 1'b0;
    end else begin
      if (state_reg.ol_cnt >= state_reg.prealarm_ms) begin
        state_next.ol_alarm = 1'b1;
      end else if (state_reg.ms_tick) begin
        state_next.ol_cnt = state_reg.ol_cnt + 1'b1;
      end
    end

    // underload pre-alarm, same timing
    if (!drive.underload_over) begin
      state_next.ul_cnt = '0;
      state_next.ul_alarm = 1'b0;
    end else begin
      if (state_reg.ul_cnt >= state_reg.prealarm_ms) begin
        state_next.ul_alarm = 1'b1;
      end else if (state_reg.ms_tick) begin
        state_next.ul_cnt = state_reg.ul_cnt + 1'b1;
      end
    end

    // index hold: a new pulse restarts the full hold
    if (z_edge) begin
      state_next.z_hold = 1'b1;
      state_next.z_cnt = Z_LAST;
    end else if (state_reg.z_cnt != '0) begin
      state_next.z_cnt = state_reg.z_cnt - 1'b1;
    end else begin
      state_next.z_hold = 1'b0;
    end

    // terminal outputs with polarity applied, except the fast terminal in pulse mode
    for (int t = 0; t < dofs_pkg::NTERM; t++) begin
      state_next.term[t] = sel[t] ^ pol_vec[t];
    end
    if (!state_reg.fast_mode) begin
      state_next.term[dofs_pkg::T_FAST] = fast_pulse_src;
    end

    // register writes
    if (reg_wr) begin
      if (reg_addr == dofs_pkg::A_FSEL0) begin
        state_next.fsel[dofs_pkg::T_OC] =
          reg_wdata[dofs_pkg::CODE_W-1:0];
      end else if (reg_addr == dofs_pkg::A_FSEL0 +
                   dofs_pkg::A_FSEL_STEP) begin
        state_next.fsel[dofs_pkg::T_FAST] =
          reg_wdata[dofs_pkg::CODE_W-1:0];
      end else if (reg_addr == dofs_pkg::A_FSEL0 +
                   8'(2 * dofs_pkg::A_FSEL_STEP)) begin
        state_next.fsel[dofs_pkg::T_RLY1] =
          reg_wdata[dofs_pkg::CODE_W-1:0];
      end else if (reg_addr == dofs_pkg::A_FSEL0 +
                   8'(3 * dofs_pkg::A_FSEL_STEP)) begin
        state_next.fsel[dofs_pkg::T_RLY2] =
          reg_wdata[dofs_pkg::CODE_W-1:0];
      end else if (reg_addr == dofs_pkg::A_POLARITY) begin
        state_next.polarity = reg_wdata[7:0];
      end else if (reg_addr == dofs_pkg::A_FAST_MODE) begin
        state_next.fast_mode = reg_wdata[0];
      end else if (reg_addr == dofs_pkg::A_CARD_EN) begin
        state_next.card_en = reg_wdata[7:0];
      end else if (reg_addr == dofs_pkg::A_VIRT) begin
        state_next.virt =
          reg_wdata[dofs_pkg::NCHAN*dofs_pkg::NTERM-1:0];
      end else if (reg_addr == dofs_pkg::A_PREALARM) begin
        state_next.prealarm_ms = reg_wdata[dofs_pkg::TIME_W-1:0];
      end else if (reg_addr == dofs_pkg::A_REACH) begin
        state_next.reach_level = reg_wdata[dofs_pkg::TIME_W-1:0];
      end
    end

    // register reads: data stand for one cycle only
    state_next.rdata = '0;
    if (reg_rd) begin
      if (reg_addr == dofs_pkg::A_FSEL0) begin
        state_next.rdata = 32'(state_reg.fsel[dofs_pkg::T_OC]);
      end else if (reg_addr == dofs_pkg::A_FSEL0 +
                   dofs_pkg::A_FSEL_STEP) begin
        state_next.rdata = 32'(state_reg.fsel[dofs_pkg::T_FAST]);
      end else if (reg_addr == dofs_pkg::A_FSEL0 +
                   8'(2 * dofs_pkg::A_FSEL_STEP)) begin
        state_next.rdata = 32'(state_reg.fsel[dofs_pkg::T_RLY1]);
      end else if (reg_addr == dofs_pkg::A_FSEL0 +
                   8'(3 * dofs_pkg::A_FSEL_STEP)) begin
        state_next.rdata = 32'(state_reg.fsel[dofs_pkg::T_RLY2]);
      end else if (reg_addr == dofs_pkg::A_POLARITY) begin
        state_next.rdata = 32'(state_reg.polarity);
      end else if (reg_addr == dofs_pkg::A_FAST_MODE) begin
        state_next.rdata = 32'(state_reg.fast_mode);
      end else if (reg_addr == dofs_pkg::A_CARD_EN) begin
        state_next.rdata = 32'(state_reg.card_en);
      end else if (reg_addr == dofs_pkg::A_VIRT) begin
        state_next.rdata = 32'(state_reg.virt);
      end else if (reg_addr == dofs_pkg::A_PREALARM) begin
        state_next.rdata = 32'(state_reg.prealarm_ms);
      end else if (reg_addr == dofs_pkg::A_REACH) begin
        state_next.rdata = 32'(state_reg.reach_level);
      end else if (reg_addr == dofs_pkg::A_STATUS) begin
        state_next.rdata = 32'({state_reg.z_hold, state_reg.ul_alarm,
                                state_reg.ol_alarm, state_reg.term});
      end
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      state_reg <= STATE_RST;
    end else begin
      state_reg <= state_next;
    end
  end

  assign reg_rdata = state_reg.rdata;
  assign open_collector_out = state_reg.term[dofs_pkg::T_OC];
  assign fast_pulse_out = state_reg.term[dofs_pkg::T_FAST];
  assign relay1_out = state_reg.term[dofs_pkg::T_RLY1];
  assign relay2_out = state_reg.term[dofs_pkg::T_RLY2];

endmodule

/* dofs_output_select_assertions.sv */
// checker: terminal levels against settings shadowed from the port
// assumes bind onto the selector; settings only change by bus writes
`timescale 1ns/1ps

module dofs_output_select_assertions #(
  parameter int MS_TICK_CYCLES = 4,
  parameter int Z_HOLD_CYCLES = 20
) (
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic [dofs_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [dofs_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [dofs_pkg::DATA_W-1:0] reg_rdata,
  input wire dofs_pkg::dofs_drive_s drive,
  input wire logic ext_fault_pin,
  input wire logic encoder_index_pin,
  input wire logic fast_pulse_src,
  input wire logic open_collector_out,
  input wire logic fast_pulse_out,
  input wire logic relay1_out,
  input wire logic relay2_out
);
  logic [5:0] c_oc;
  logic [5:0] c_r1;
  logic [5:0] c_r2;
  logic [7:0] pol;
  logic fmode;
  logic [15:0] lvl;
  // shadow of the settings, updated on the same edge as the block
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      c_oc <= 6'h00;
      c_r1 <= 6'h01;
      c_r2 <= 6'h05;
      pol <= 8'h00;
      fmode <= 1'b0;
      lvl <= 16'h0000;
    end else if (reg_wr) begin
      if (reg_addr == 8'h00) c_oc <= reg_wdata[5:0];
      if (reg_addr == 8'h08) c_r1 <= reg_wdata[5:0];
      if (reg_addr == 8'h0c) c_r2 <= reg_wdata[5:0];
      if (reg_addr == 8'h10) pol <= reg_wdata[7:0];
      if (reg_addr == 8'h14) fmode <= reg_wdata[0];
      if (reg_addr == 8'h24) lvl <= reg_wdata[15:0];
    end
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!arst_n);
  sequence s_on;
    open_collector_out != pol[0];
  endsequence
  sequence s_idx;
    c_oc == 6'h1b && $rose(encoder_index_pin);
  endsequence
  sequence s_ext;
    c_oc == 6'h14 && $rose(ext_fault_pin);
  endsequence
  property p_none;
    c_oc == 6'h00 |=> open_collector_out == $past(pol[0]);
  endproperty
  property p_fault;
    c_oc == 6'h05 |=> open_collector_out == ($past(drive.fault) ^ $past(pol[0]));
  endproperty
  property p_run;
    c_r1 == 6'h01 |=> relay1_out ==
      (($past(drive.running) & $past(drive.freq_out_nz)) ^ $past(pol[4]));
  endproperty
  property p_same;
    c_oc == 6'h05 && c_r2 == 6'h05 && pol[0] == pol[5]
      |=> relay2_out == open_collector_out;
  endproperty
  property p_pulse;
    !fmode |=> fast_pulse_out == $past(fast_pulse_src);
  endproperty
  property p_unused;
    c_oc inside {6, 7, 8, 18, 19, 21, 22, [33:35], [38:40], [42:63]}
      |=> open_collector_out == $past(pol[0]);
  endproperty
  property p_reach;
    c_oc == 6'h25 |=> open_collector_out ==
      (($past(drive.ramp_ref_freq) > $past(lvl)) ^ $past(pol[0]));
  endproperty
  property p_index;
    s_idx |-> ##[2:6] s_on [*8];
  endproperty
  property p_ext;
    s_ext |-> ##[1:4] s_on;
  endproperty
  a_none: assert property (p_none) else $error("idle terminal moved");
  a_fault: assert property (p_fault) else $error("fault code wrong");
  a_run: assert property (p_run) else $error("relay one not running");
  a_same: assert property (p_same) else $error("shared code differs");
  a_pulse: assert property (p_pulse) else $error("pulse path wrong");
  a_unused: assert property (p_unused) else $error("unused code on");
  a_reach: assert property (p_reach) else $error("reach code wrong");
  a_index: assert property (p_index) else $error("index hold short");
  a_ext: assert property (p_ext) else $error("external fault late");
endmodule

/* dofs_load_model.sv */
// far side: equipment wired to the four terminals, reads their levels
// assumes the terminals are plain logic levels, high means on
`timescale 1ns/1ps

module dofs_load_model (
  input wire logic open_collector_out,
  input wire logic fast_pulse_out,
  input wire logic relay1_out,
  input wire logic relay2_out,
  output logic [3:0] term_word
);
  assign term_word = {relay2_out, relay1_out, fast_pulse_out,
                      open_collector_out};
endmodule

/* dofs_output_select_tb_top.sv */
// testbench: drives settings and conditions, judges the terminals
// assumes the selector, its package, the load model and the checker
`timescale 1ns/1ps

module dofs_output_select_tb_top;
  localparam int MS_T = 4;
  localparam int ZH = 20;
  logic clk_sys = 1'b0;
  logic arst_n = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [31:0] rdata;
  dofs_pkg::dofs_drive_s drv = '0;
  logic efp = 1'b0;
  logic eip = 1'b0;
  logic fps = 1'b0;
  logic oc;
  logic fpo;
  logic r1;
  logic r2;
  logic [3:0] seen;
  int n_fail = 0;
  int n_checks = 0;
  int codes[26] = '{1, 2, 3, 4, 5, 9, 10, 11, 12, 13, 14, 15, 16, 17, 23,
                    24, 25, 26, 28, 29, 30, 31, 32, 36, 37, 41};
  int idle[7] = '{0, 6, 7, 8, 34, 42, 63};
  logic [7:0] ra[7] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h80};
  logic [31:0] rv[7] = '{32'h0, 32'h0, 32'h1, 32'h5, 32'h0, 32'h0, 32'h0};
  always #20 clk_sys = ~clk_sys;
  dofs_output_select #(.MS_TICK_CYCLES(MS_T), .Z_HOLD_CYCLES(ZH))
  i_dofs_output_select (.clk_sys(clk_sys), .arst_n(arst_n),
    .reg_addr(addr), .reg_wdata(wdata), .reg_wr(wr), .reg_rd(rd),
    .reg_rdata(rdata), .drive(drv), .ext_fault_pin(efp),
    .encoder_index_pin(eip), .fast_pulse_src(fps),
    .open_collector_out(oc), .fast_pulse_out(fpo),
    .relay1_out(r1), .relay2_out(r2));
  dofs_load_model i_dofs_load_model (.open_collector_out(oc),
    .fast_pulse_out(fpo), .relay1_out(r1), .relay2_out(r2),
    .term_word(seen));
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  task automatic look(input int n);
    tick(n);
    @(negedge clk_sys);
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk_sys);
    wr <= 1'b0;
  endtask
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic chk_reg(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk_sys);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk_sys);
    rd <= 1'b0;
    @(negedge clk_sys);
    chk("register", e, rdata);
  endtask
  function automatic dofs_pkg::dofs_drive_s cond(input int c);
    dofs_pkg::dofs_drive_s d;
    d = '0;
    case (c)
      1, 3: {d.running, d.freq_out_nz} = 2'b11;
      2: {d.running, d.freq_out_nz, d.run_fwd} = 3'b111;
      4: {d.jogging, d.freq_out_nz} = 2'b11;
      5: d.fault = 1'b1;
      9: {d.running, d.out_freq_zero, d.ref_freq_zero} = 3'b111;
      10: d.at_upper = 1'b1;
      11: d.at_lower = 1'b1;
      12: {d.main_pwr_ok, d.ctrl_pwr_ok, d.ready} = 3'b111;
      13: d.pre_excite = 1'b1;
      14: d.overload_over = 1'b1;
      15: d.underload_over = 1'b1;
      16: d.seq_stage_done = 1'b1;
      17: d.seq_cycle_done = 1'b1;
      26: d.dc_bus_above_uv = 1'b1;
      28: d.pulse_superpose = 1'b1;
      29: d.safe_torque_off = 1'b1;
      30: d.pos_done = 1'b1;
      31: d.zero_done = 1'b1;
      32: d.index_done = 1'b1;
      36: d.mode_switch_done = 1'b1;
      37: d.ramp_ref_freq = 16'h0011;
      41: d.card_first_out = 1'b1;
      default: d = '0;
    endcase
    return d;
  endfunction
  task automatic t_reset();
    for (int i = 0; i < 7; i++) chk_reg(ra[i], rv[i]);
    chk("terminals", 32'h0, {28'h0, seen});
    $display("done t_reset");
  endtask
  task automatic t_codes();
    wr_reg(8'h18, 32'h1);
    wr_reg(8'h24, 32'h10);
    wr_reg(8'h20, 32'h0);
    foreach (codes[i]) begin
      wr_reg(8'h00, 32'(codes[i]));
      wr_reg(8'h1c, 32'h111);
      drv <= cond(codes[i]);
      look(4);
      chk("code on", 32'h1, {31'h0, seen[0]});
      wr_reg(8'h1c, 32'h0);
      drv <= '0;
      look(4);
      chk("code off", 32'h0, {31'h0, seen[0]});
    end
    $display("done t_codes");
  endtask
  task automatic t_idle();
    wr_reg(8'h1c, 32'hfff);
    drv <= '1;
    foreach (idle[i]) begin
      wr_reg(8'h00, 32'(idle[i]));
      look(3);
      chk("idle code", 32'h0, {31'h0, seen[0]});
    end
    wr_reg(8'h18, 32'h2);
    wr_reg(8'h00, 32'd41);
    look(3);
    chk("card gated", 32'h0, {31'h0, seen[0]});
    @(posedge clk_sys);
    drv <= '0;
    wr_reg(8'h1c, 32'h0);
    $display("done t_idle");
  endtask
  task automatic t_pol_same();
    wr_reg(8'h00, 32'd0);
    wr_reg(8'h10, 32'h1);
    look(2);
    chk("inverted idle", 32'h1, {31'h0, seen[0]});
    wr_reg(8'h10, 32'h0);
    wr_reg(8'h00, 32'd5);
    drv <= cond(5);
    look(2);
    chk("shared fault", 32'h9, {28'h0, seen & 4'h9});
    wr_reg(8'h10, 32'h21);
    look(2);
    chk("inverted fault", 32'h0, {28'h0, seen & 4'h9});
    wr_reg(8'h10, 32'h0);
    drv <= cond(1);
    look(2);
    chk("relay one run", 32'h4, {28'h0, seen & 4'h4});
    @(posedge clk_sys);
    drv <= '0;
    $display("done t_pol_same");
  endtask
  task automatic t_fast();
    fps <= 1'b1;
    @(negedge clk_sys);
    chk("pulse early", 32'h0, {31'h0, fpo});
    @(negedge clk_sys);
    chk("pulse pass", 32'h1, {31'h0, fpo});
    wr_reg(8'h04, 32'd5);
    wr_reg(8'h14, 32'h1);
    fps <= 1'b0;
    drv <= cond(5);
    look(2);
    chk("fast digital", 32'h1, {31'h0, fpo});
    @(posedge clk_sys);
    drv <= '0;
    fps <= 1'b1;
    look(2);
    chk("fast digital off", 32'h0, {31'h0, fpo});
    $display("done t_fast");
  endtask
  task automatic t_pins();
    wr_reg(8'h00, 32'd20);
    efp <= 1'b1;
    look(5);
    chk("ext fault", 32'h1, {31'h0, seen[0]});
    @(posedge clk_sys);
    efp <= 1'b0;
    look(5);
    chk("ext clear", 32'h0, {31'h0, seen[0]});
    wr_reg(8'h00, 32'd27);
    eip <= 1'b1;
    look(6);
    chk("index on", 32'h1, {31'h0, seen[0]});
    look(ZH);
    chk("index off", 32'h0, {31'h0, seen[0]});
    @(posedge clk_sys);
    eip <= 1'b0;
    $display("done t_pins");
  endtask
  task automatic t_alarm();
    wr_reg(8'h20, 32'h3);
    wr_reg(8'h00, 32'd14);
    drv <= cond(14);
    look(4);
    chk("alarm early", 32'h0, {31'h0, seen[0]});
    look(3 * MS_T + 8);
    chk("alarm on", 32'h1, {31'h0, seen[0]});
    chk_reg(8'h28, 32'h11);
    @(posedge clk_sys);
    arst_n <= 1'b0;
    look(1);
    chk("terminals in reset", 32'h0, {28'h0, seen});
    @(posedge clk_sys);
    arst_n <= 1'b1;
    drv <= '0;
    chk_reg(8'h00, 32'h0);
    $display("done t_alarm");
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  initial begin
    tick(20000);
    n_fail++;
    close_out();
  end
  initial begin
    tick(16);
    arst_n <= 1'b1;
    t_reset();
    t_codes();
    t_idle();
    t_pol_same();
    t_fast();
    t_pins();
    t_alarm();
    close_out();
  end
endmodule

bind dofs_output_select dofs_output_select_assertions #(
  .MS_TICK_CYCLES(MS_TICK_CYCLES), .Z_HOLD_CYCLES(Z_HOLD_CYCLES)
) i_dofs_output_select_assertions (.clk_sys(clk_sys), .arst_n(arst_n),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .drive(drive),
  .ext_fault_pin(ext_fault_pin), .encoder_index_pin(encoder_index_pin),
  .fast_pulse_src(fast_pulse_src), .open_collector_out(open_collector_out),
  .fast_pulse_out(fast_pulse_out), .relay1_out(relay1_out),
  .relay2_out(relay2_out));
